// ==== hdl/uem_pkg.sv ====
// Package: register map, field positions, reset values and timing of the serial port
// Assumes: used by uem_top and uem_shift_unit; all references are written uem_pkg::name
package uem_pkg;
   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [5:0] ADDR_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_DATA = 6'h04;
   localparam logic [5:0] ADDR_BAUD = 6'h08;
   localparam logic [5:0] ADDR_IRQ_STATUS = 6'h0c;
   localparam logic [5:0] ADDR_IRQ_MASK = 6'h10;
   // ------------------------------------------------------------
   // Control register fields
   // ------------------------------------------------------------
   localparam int CTL_FRAME_LEN = 7;
   localparam int CTL_MULTIPROC = 5;
   localparam int CTL_RX_ENABLE = 4;
   localparam int CTL_STOP_BIT = 2;
   localparam int CTL_TX_DONE = 1;
   localparam int CTL_RX_DONE = 0;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   // ------------------------------------------------------------
   // Interrupt status and mask fields
   // ------------------------------------------------------------
   localparam int IRQ_TX_DONE = 0;
   localparam int IRQ_RX_DONE = 1;
   localparam int IRQ_OVERRUN = 2;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
   // ------------------------------------------------------------
   // Frame and timing
   // ------------------------------------------------------------
   localparam int FRAME_BITS = 10;
   localparam int DATA_BITS = 8;
   localparam int OVERSAMPLE = 16;
   localparam int CLK_HZ = 125000000;
   localparam int BAUD_DEFAULT = 115200;
   localparam logic [15:0] BAUD_DIV_RESET = 16'(CLK_HZ / (BAUD_DEFAULT * OVERSAMPLE));
endpackage

// ==== hdl/uem_shift_unit.sv ====
// Shift unit: transmit and receive serialisers driven by an oversampling tick
// Assumes: one clock, tick is a one-cycle enable at 16x the bit rate, rx pin synchronous
`timescale 1ns/1ns
module uem_shift_unit (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic tick,
   input wire logic tx_start,
   input wire logic [7:0] tx_byte,
   input wire logic rx_enable,
   input wire logic serial_receive_pin,
   output logic serial_transmit_pin,
   output logic tx_busy,
   output logic tx_data_sent,
   output logic rx_frame_done,
   output logic [7:0] rx_byte,
   output logic rx_stop
);
   typedef enum logic [1:0] {
      UEM_IDLE = 2'b00,
      UEM_START = 2'b01,
      UEM_DATA = 2'b10,
      UEM_STOP = 2'b11
   } uem_phase_e;

   uem_phase_e tx_state_reg;
   uem_phase_e rx_state_reg;
   logic [3:0] tx_sub_reg;
   logic [3:0] tx_bit_reg;
   logic [7:0] tx_shift_reg;
   logic [3:0] rx_sub_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic rx_prev_reg;

   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_state_reg <= UEM_IDLE;
         tx_sub_reg <= 4'h0;
         tx_bit_reg <= 4'h0;
         tx_shift_reg <= 8'h00;
         serial_transmit_pin <= 1'b1;
         tx_data_sent <= 1'b0;
      end else begin
         tx_data_sent <= 1'b0;
         unique case (tx_state_reg)
            UEM_IDLE: begin
               serial_transmit_pin <= 1'b1;
               if (tx_start) begin
                  tx_shift_reg <= tx_byte;
                  tx_sub_reg <= 4'h0;
                  tx_state_reg <= UEM_START;
                  serial_transmit_pin <= 1'b0; // RULE1
               end
            end
            UEM_START: begin
               if (tick) begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
                  if (tx_sub_reg == 4'hf) begin
                     tx_state_reg <= UEM_DATA;
                     tx_bit_reg <= 4'h0;
                     serial_transmit_pin <= tx_shift_reg[0]; // RULE1
                  end
               end
            end
            UEM_DATA: begin
               if (tick) begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
                  if (tx_sub_reg == 4'hf) begin
                     if (tx_bit_reg == 4'(uem_pkg::DATA_BITS - 1)) begin
                        tx_state_reg <= UEM_STOP;
                        serial_transmit_pin <= 1'b1;
                        tx_data_sent <= 1'b1; // RULE5
                     end else begin
                        tx_bit_reg <= tx_bit_reg + 4'h1;
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        serial_transmit_pin <= tx_shift_reg[1]; // RULE3
                     end
                  end
               end
            end
            UEM_STOP: begin
               if (tick) begin
                  tx_sub_reg <= tx_sub_reg + 4'h1;
                  if (tx_sub_reg == 4'hf) begin
                     tx_state_reg <= UEM_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_busy <= 1'b0;
      end else begin
         tx_busy <= (tx_state_reg != UEM_IDLE) || tx_start;
      end
   end

   // ------------------------------------------------------------
   // Receiver: start edge, mid-bit sampling
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rx_state_reg <= UEM_IDLE;
         rx_sub_reg <= 4'h0;
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
         rx_prev_reg <= 1'b1;
         rx_frame_done <= 1'b0;
         rx_byte <= 8'h00;
         rx_stop <= 1'b0;
      end else begin
         rx_frame_done <= 1'b0;
         rx_prev_reg <= serial_receive_pin;
         unique case (rx_state_reg)
            UEM_IDLE: begin
               if (rx_enable && rx_prev_reg && !serial_receive_pin) begin // RULE6
                  rx_state_reg <= UEM_START;
                  rx_sub_reg <= 4'h0;
               end
            end
            UEM_START: begin
               if (tick) begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == 4'h7) begin
                     if (serial_receive_pin) begin
                        rx_state_reg <= UEM_IDLE;
                     end else begin
                        rx_state_reg <= UEM_DATA;
                        rx_sub_reg <= 4'h0;
                        rx_bit_reg <= 4'h0;
                     end
                  end
               end
            end
            UEM_DATA: begin
               if (tick) begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == 4'hf) begin
                     rx_shift_reg <= {serial_receive_pin, rx_shift_reg[7:1]}; // RULE1
                     if (rx_bit_reg == 4'(uem_pkg::DATA_BITS - 1)) begin
                        rx_state_reg <= UEM_STOP;
                     end else begin
                        rx_bit_reg <= rx_bit_reg + 4'h1;
                     end
                  end
               end
            end
            UEM_STOP: begin
               if (tick) begin
                  rx_sub_reg <= rx_sub_reg + 4'h1;
                  if (rx_sub_reg == 4'hf) begin
                     rx_state_reg <= UEM_IDLE;
                     rx_byte <= rx_shift_reg; // RULE3
                     rx_stop <= serial_receive_pin; // RULE3
                     rx_frame_done <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
endmodule // uem_shift_unit

// ==== hdl/uem_top.sv ====
// Top: 8-bit frame serial port with a classic Wishbone register slave and one interrupt output
// Assumes: single 125 MHz clock, asynchronous active-low reset, receive pin synchronous to the clock
//
// Notes on behaviour
// RULE1 - A character is start bit, eight data bits LSB first, stop bit: ten bits.
// RULE2 - A control bit selects 8-bit or 9-bit frames; here the bit is only stored and read back, and frames are always 8-bit.
// RULE3 - Send on the transmit pin, receive on the receive pin; data and stop stored.
// RULE4 - Writing the data buffer starts transmission of that byte; here a write while the transmitter is busy is ignored.
// RULE5 - Transmit-done sets when data bits are sent, at the start of stop bit.
// RULE6 - A new character is received only while receiver enable is one.
// RULE7 - Accept only if receive-done is zero and, with multiprocessor check, stop is one.
// RULE8 - On acceptance store data, store stop bit and set receive-done.
// RULE9 - On refusal leave data and stop bit unchanged and do not set receive-done.
// RULE10 - On overrun the first received byte stays latched; later data are dropped.
// RULE11 - With interrupts enabled, setting either done flag requests an interrupt.
// RULE12 - The done flags stay set until software clears them.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
module uem_top #(
   parameter logic [15:0] BAUD_DIV_DEFAULT = uem_pkg::BAUD_DIV_RESET
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic serial_receive_pin,
   output logic serial_transmit_pin,
   output logic irq
);
   logic frame_length_select;
   logic multiproc_check_enable;
   logic receiver_enable_bit;
   logic received_stop_bit;
   logic transmit_done_flag;
   logic receive_done_flag;
   logic [7:0] serial_data_buffer;
   logic [15:0] baud_div_reg;
   logic [15:0] baud_cnt_reg;
   logic tick_reg;
   logic tx_start_reg;
   logic [7:0] tx_byte_reg;
   logic [2:0] irq_status_reg;
   logic [2:0] irq_mask_reg;
   logic tx_busy;
   logic tx_data_sent;
   logic rx_frame_done;
   logic [7:0] rx_byte;
   logic rx_stop;
   logic bus_req;
   logic wr_req;
   logic rd_req;
   logic accept;
   logic overrun;
   logic sw_clear_tx;
   logic sw_clear_rx;

   // Word offset within the map; the low two byte-address bits are ignored
   function automatic logic hit(input logic [31:0] adr, input logic [5:0] offs);
      hit = (adr[5:2] == offs[5:2]) && (adr[31:6] == 26'h0);
   endfunction

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_req = bus_req && wb_we_i && wb_sel_i[0];
   assign rd_req = bus_req && !wb_we_i;

   assign accept = rx_frame_done && !receive_done_flag
      && (!multiproc_check_enable || rx_stop); // RULE7
   assign overrun = rx_frame_done && receive_done_flag;

   assign sw_clear_tx = wr_req && hit(wb_adr_i, uem_pkg::ADDR_CONTROL) && !wb_dat_i[uem_pkg::CTL_TX_DONE];
   assign sw_clear_rx = wr_req && hit(wb_adr_i, uem_pkg::ADDR_CONTROL) && !wb_dat_i[uem_pkg::CTL_RX_DONE];

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
      end
   end

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         frame_length_select <= uem_pkg::CONTROL_RESET[uem_pkg::CTL_FRAME_LEN];
         multiproc_check_enable <= uem_pkg::CONTROL_RESET[uem_pkg::CTL_MULTIPROC];
         receiver_enable_bit <= uem_pkg::CONTROL_RESET[uem_pkg::CTL_RX_ENABLE];
      end else if (wr_req && hit(wb_adr_i, uem_pkg::ADDR_CONTROL)) begin
         frame_length_select <= wb_dat_i[uem_pkg::CTL_FRAME_LEN]; // RULE2
         multiproc_check_enable <= wb_dat_i[uem_pkg::CTL_MULTIPROC];
         receiver_enable_bit <= wb_dat_i[uem_pkg::CTL_RX_ENABLE];
      end
   end

   // Set by hardware wins over the software clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         transmit_done_flag <= 1'b0;
      end else if (tx_data_sent) begin
         transmit_done_flag <= 1'b1; // RULE5
      end else if (sw_clear_tx) begin
         transmit_done_flag <= 1'b0; // RULE12
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         receive_done_flag <= 1'b0;
      end else if (accept) begin
         receive_done_flag <= 1'b1; // RULE8
      end else if (sw_clear_rx) begin
         receive_done_flag <= 1'b0; // RULE12
      end
   end

   // ------------------------------------------------------------
   // Receive data and stop bit, loaded only on acceptance
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         serial_data_buffer <= 8'h00;
         received_stop_bit <= 1'b0;
      end else if (accept) begin
         serial_data_buffer <= rx_byte; // RULE8
         received_stop_bit <= rx_stop; // RULE8
      end
      // Refused or overrun frames leave buffer and stop bit alone  RULE9 RULE10
   end

   // ------------------------------------------------------------
   // Transmit start
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tx_start_reg <= 1'b0;
         tx_byte_reg <= 8'h00;
      end else begin
         tx_start_reg <= 1'b0;
         if (wr_req && hit(wb_adr_i, uem_pkg::ADDR_DATA) && !tx_busy && !tx_start_reg) begin
            tx_start_reg <= 1'b1; // RULE4
            tx_byte_reg <= wb_dat_i[7:0];
         end
      end
   end

   // ------------------------------------------------------------
   // Baud divider: one-cycle tick at 16x bit rate
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         baud_div_reg <= BAUD_DIV_DEFAULT;
      end else if (wr_req && hit(wb_adr_i, uem_pkg::ADDR_BAUD)) begin
         baud_div_reg <= (wb_dat_i[15:0] == 16'h0) ? 16'h1 : wb_dat_i[15:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         baud_cnt_reg <= 16'h0;
         tick_reg <= 1'b0;
      end else if (baud_cnt_reg >= baud_div_reg - 16'h1) begin
         baud_cnt_reg <= 16'h0;
         tick_reg <= 1'b1;
      end else begin
         baud_cnt_reg <= baud_cnt_reg + 16'h1;
         tick_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Interrupts: sticky status, cleared by a read, set wins
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_status_reg <= 3'h0;
      end else begin
         irq_status_reg <= (rd_req && hit(wb_adr_i, uem_pkg::ADDR_IRQ_STATUS)) ? 3'h0 : irq_status_reg;
         if (tx_data_sent) begin
            irq_status_reg[uem_pkg::IRQ_TX_DONE] <= 1'b1; // RULE11
         end
         if (accept) begin
            irq_status_reg[uem_pkg::IRQ_RX_DONE] <= 1'b1; // RULE11
         end
         if (overrun) begin
            irq_status_reg[uem_pkg::IRQ_OVERRUN] <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_mask_reg <= uem_pkg::IRQ_MASK_RESET;
      end else if (wr_req && hit(wb_adr_i, uem_pkg::ADDR_IRQ_MASK)) begin
         irq_mask_reg <= wb_dat_i[2:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status_reg & irq_mask_reg); // RULE11
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wb_dat_o <= 32'h0;
      end else if (rd_req) begin
         wb_dat_o <= 32'h0;
         if (hit(wb_adr_i, uem_pkg::ADDR_CONTROL)) begin
            wb_dat_o[uem_pkg::CTL_FRAME_LEN] <= frame_length_select;
            wb_dat_o[uem_pkg::CTL_MULTIPROC] <= multiproc_check_enable;
            wb_dat_o[uem_pkg::CTL_RX_ENABLE] <= receiver_enable_bit;
            wb_dat_o[uem_pkg::CTL_STOP_BIT] <= received_stop_bit;
            wb_dat_o[uem_pkg::CTL_TX_DONE] <= transmit_done_flag;
            wb_dat_o[uem_pkg::CTL_RX_DONE] <= receive_done_flag;
         end else if (hit(wb_adr_i, uem_pkg::ADDR_DATA)) begin
            wb_dat_o[7:0] <= serial_data_buffer;
         end else if (hit(wb_adr_i, uem_pkg::ADDR_BAUD)) begin
            wb_dat_o[15:0] <= baud_div_reg;
         end else if (hit(wb_adr_i, uem_pkg::ADDR_IRQ_STATUS)) begin
            wb_dat_o[2:0] <= irq_status_reg;
         end else if (hit(wb_adr_i, uem_pkg::ADDR_IRQ_MASK)) begin
            wb_dat_o[2:0] <= irq_mask_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // Shift unit
   // ------------------------------------------------------------
   uem_shift_unit u_shift (
      .core_clk(core_clk),
      .resetn(resetn),
      .tick(tick_reg),
      .tx_start(tx_start_reg),
      .tx_byte(tx_byte_reg),
      .rx_enable(receiver_enable_bit),
      .serial_receive_pin(serial_receive_pin),
      .serial_transmit_pin(serial_transmit_pin),
      .tx_busy(tx_busy),
      .tx_data_sent(tx_data_sent),
      .rx_frame_done(rx_frame_done),
      .rx_byte(rx_byte),
      .rx_stop(rx_stop)
   );
endmodule // uem_top

// ==== sim/tb_top.sv ====
// Testbench: corner and random traffic through the bus and the line of the serial port
// Assumes: divider parameter 1, so a bit is 16 clocks; partner model on the line
`timescale 1ns/1ns
module tb_top;
   localparam int BIT = 16;
   localparam logic [31:0] A_CTL = 32'(uem_pkg::ADDR_CONTROL);
   localparam logic [31:0] A_DATA = 32'(uem_pkg::ADDR_DATA);
   localparam logic [31:0] A_BAUD = 32'(uem_pkg::ADDR_BAUD);
   localparam logic [31:0] A_STAT = 32'(uem_pkg::ADDR_IRQ_STATUS);
   localparam logic [31:0] A_MASK = 32'(uem_pkg::ADDR_IRQ_MASK);
   logic core_clk, resetn, cyc, stb, we, ack, irq, tx_line, rx_line;
   logic [31:0] adr, dat, rdat, q;
   logic [3:0] sel;
   logic [7:0] b, c;
   int n_errors, checks_done, cycles, n;
   uem_top #(.BAUD_DIV_DEFAULT(16'h0001)) u_dut (
      .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .serial_receive_pin(rx_line),
      .serial_transmit_pin(tx_line), .irq(irq));
   uem_line_partner #(.BIT_CLKS(BIT)) u_peer (.core_clk(core_clk), .line_in(tx_line), .line_out(rx_line));
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 12000) begin
         n_errors++;
         $display("MISMATCH run length expected 11999 seen 12000");
         complete_run();
      end
   end
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [31:0] ctl_exp(input logic [7:0] cfg, input logic stp, input logic txd, input logic rxd);
      return {24'h0, cfg} | (32'(stp) << uem_pkg::CTL_STOP_BIT) | (32'(txd) << uem_pkg::CTL_TX_DONE)
         | (32'(rxd) << uem_pkg::CTL_RX_DONE);
   endfunction
   // One classic bus cycle; the request stands until the rising edge at which ack is sampled high
   task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w);
      @(posedge core_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do @(posedge core_clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic expect_reg(input logic [31:0] a, input string what, input logic [31:0] exp);
      xfer(a, 32'h0, 1'b0);
      check(what, q, exp);
   endtask
   // Waits for the partner to take a frame, then for the stop bit to end
   task automatic wait_peer(input int old);
      while (u_peer.rx_count == old) @(negedge core_clk);
      repeat (BIT) @(posedge core_clk);
   endtask
   task automatic rx_frame(input logic [7:0] v, input logic s, input logic [31:0] ctl, input logic [7:0] d);
      u_peer.send_frame(v, s);
      expect_reg(A_CTL, "control", ctl);
      expect_reg(A_DATA, "rx data", {24'h0, d});
   endtask
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 32'h0;
      dat = 32'h0;
      sel = 4'h0;
      resetn = 1'b0;
      n = $urandom(32'h0844a835);
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      expect_reg(A_CTL, "control reset", 32'(uem_pkg::CONTROL_RESET));
      expect_reg(A_BAUD, "divider reset", 32'h1);
      expect_reg(A_STAT, "status reset", 32'h0);
      expect_reg(32'h40, "unmapped", 32'h0);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
         n = u_peer.rx_count;
         xfer(A_DATA, {24'h0, b}, 1'b1);
         wait_peer(n);
         check("tx byte", {24'h0, u_peer.rx_last}, {24'h0, b});
         check("tx stop", {31'h0, u_peer.rx_stop}, 32'h1);
         check("irq masked", {31'h0, irq}, 32'h0);
      end
      expect_reg(A_CTL, "tx done held", ctl_exp(8'h00, 1'b0, 1'b1, 1'b0));
      xfer(A_CTL, 32'h0, 1'b1);
      expect_reg(A_CTL, "tx done cleared", 32'h0);
      expect_reg(A_STAT, "status tx", 32'h1);
      expect_reg(A_STAT, "status cleared", 32'h0);
      $display("test transmit done");
      // Mask bit 0 unmasks tx done
      xfer(A_MASK, 32'h1, 1'b1);
      expect_reg(A_MASK, "mask", 32'h1);
      n = u_peer.rx_count;
      xfer(A_DATA, {24'h0, 8'($urandom)}, 1'b1);
      while (irq !== 1'b1) @(negedge core_clk);
      check("frames at tx done", 32'(u_peer.rx_count), 32'(n));
      check("line at tx done", {31'h0, tx_line}, 32'h1);
      wait_peer(n);
      expect_reg(A_STAT, "status tx", 32'h1);
      repeat (3) @(negedge core_clk);
      check("irq after read", {31'h0, irq}, 32'h0);
      xfer(A_MASK, 32'h0, 1'b1);
      $display("test interrupt done");
      xfer(A_CTL, 32'h90, 1'b1);
      b = 8'($urandom);
      // Second byte always differs so that a lost overrun shows in the data
      c = b ^ 8'(($urandom % 255) + 1);
      rx_frame(b, 1'b1, ctl_exp(8'h90, 1'b1, 1'b0, 1'b1), b);
      rx_frame(c, 1'b1, ctl_exp(8'h90, 1'b1, 1'b0, 1'b1), b);
      expect_reg(A_STAT, "status rx", 32'h6);
      xfer(A_CTL, 32'h30, 1'b1);
      rx_frame(c, 1'b0, ctl_exp(8'h30, 1'b1, 1'b0, 1'b0), b);
      rx_frame(c, 1'b1, ctl_exp(8'h30, 1'b1, 1'b0, 1'b1), c);
      xfer(A_CTL, 32'h10, 1'b1);
      b = ~c;
      rx_frame(b, 1'b0, ctl_exp(8'h10, 1'b0, 1'b0, 1'b1), b);
      xfer(A_CTL, 32'h0, 1'b1);
      rx_frame(c, 1'b1, ctl_exp(8'h00, 1'b0, 1'b0, 1'b0), b);
      $display("test receive done");
      complete_run();
   end
endmodule // tb_top

// ==== sim/uem_line_partner.sv ====
// Partner: remote transceiver on the serial line, 8 data bits and one stop bit
// Assumes: one bit lasts BIT_CLKS core clocks; the line idles high
`timescale 1ns/1ns
module uem_line_partner #(
   parameter int BIT_CLKS = 16
) (
   input wire logic core_clk,
   input wire logic line_in,
   output logic line_out
);
   logic [7:0] rx_last;
   logic [7:0] sh;
   logic rx_stop;
   int rx_count;
   // Start bit, data LSB first, stop bit, then one idle bit
   task automatic send_frame(input logic [7:0] v, input logic s);
      logic [10:0] f;
      f = {1'b1, s, v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge core_clk);
         line_out <= f[i];
         repeat (BIT_CLKS - 1) @(posedge core_clk);
      end
   endtask
   // Samples each bit in its middle
   initial begin
      line_out = 1'b1;
      rx_count = 0;
      forever begin
         @(negedge line_in);
         repeat (BIT_CLKS / 2) @(posedge core_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge core_clk);
            sh[i] = line_in;
         end
         repeat (BIT_CLKS) @(posedge core_clk);
         rx_stop = line_in;
         rx_last = sh;
         rx_count++;
      end
   end
endmodule // uem_line_partner

// ==== sim/uem_top_monitor.sv ====
// Checker: bus handshake and transmit line assertions for the serial port top
// Assumes: bound into uem_top; a bit lasts 16 divider ticks
`timescale 1ns/1ns
module uem_top_monitor #(
   parameter logic [15:0] BAUD_DIV_DEFAULT = 16'h0001
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic serial_receive_pin,
   input wire logic serial_transmit_pin,
   input wire logic irq
);
   localparam int BIT = 16 * int'(BAUD_DIV_DEFAULT);
   logic [15:0] low_cnt;
   logic [15:0] high_cnt;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // Lengths of the current low and high runs of the transmit line
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         low_cnt <= 16'h0;
         high_cnt <= 16'hffff;
      end else if (!serial_transmit_pin) begin
         low_cnt <= low_cnt + 16'h1;
         high_cnt <= 16'h0;
      end else begin
         low_cnt <= 16'h0;
         high_cnt <= (high_cnt == 16'hffff) ? high_cnt : high_cnt + 16'h1;
      end
   end
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[31:6] != 26'h0 |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_tx_start_bit: assert property (
      wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 32'(uem_pkg::ADDR_DATA) && high_cnt >= 16'(10 * BIT)
      |=> !serial_transmit_pin) else $error("no start bit after data write");
   a_bit_width: assert property ($rose(serial_transmit_pin) |-> low_cnt % BIT == 0)
      else $error("low run not whole bits");
   a_low_run_max: assert property (!serial_transmit_pin |-> low_cnt < 16'(9 * BIT))
      else $error("low run longer than frame allows");
   a_line_idle_reset: assert property ($rose(resetn) |-> serial_transmit_pin)
      else $error("line not idle after reset");
   a_irq_reset: assert property ($rose(resetn) |-> !irq)
      else $error("irq high after reset");
   c_tx_frame: cover property ($fell(serial_transmit_pin));
   c_read: cover property (wb_ack_o && !wb_we_i);
   c_irq: cover property ($rose(irq));
endmodule // uem_top_monitor
bind uem_top uem_top_monitor #(.BAUD_DIV_DEFAULT(BAUD_DIV_DEFAULT)) u_mon (
   .core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .serial_receive_pin(serial_receive_pin), .serial_transmit_pin(serial_transmit_pin), .irq(irq));
